// [logic/core_timing.sv]
// Purpose: core end: timing, reset state and single-step halt
// Assumes: instruction decode supplies clock-out enable and two-cycle hints
// Notes:   program counter advances by one per instruction as a stand-in
//
// How it works
// - oscillator divided by three gives states
// - clock-out enable drives test0; reset clears
// - five states per machine cycle
// - address strobe pulses once per machine cycle
// - timer tick every thirty-two cycles
// - power-up reset held ten milliseconds externally
// - five machine cycles reset suffice
// - strobes keep running during reset
// - reset zeroes pc, sp, banks
// - reset sets ports to input; bus floats only with external program select low
// - reset kills interrupts, timer, flags
// - test1 sampled in fourth state
// - controller pulls step request low
// - halt at next fetch, after two-cycle ops
// - strobe held high while halted
// - next address on bus and port2 low
// - request high resumes, strobe falls
// - re-request soon after fall, else run
// - bus buffer lost, address valid at rise
// - stepper preset keeps request high
// - step one passes only while strobe high
module core_timing #(
  parameter int TICK_DIV = tick_pkg::CYC_PER_TICK
) (
  input  wire logic                     mclk,
  input  wire logic                     arst_n,
  input  wire logic                     external_program_select,
  input  wire logic                     clock_out_enable_instr,
  input  wire logic                     two_cycle_instr,
  input  wire logic                     test1_pin,
  input  wire logic                     timer_start,
  input  wire logic                     flag_set,
  step_if.core                          lnk,
  output logic                          timer_tick,
  output logic                          test1_sample,
  output logic                          halted,
  output logic [tick_pkg::PC_W-1:0]     pc,
  output logic [tick_pkg::SP_W-1:0]     sp,
  output logic                          reg_bank,
  output logic                          mem_bank,
  output logic [1:0]                    port_out_en,
  output logic [1:0]                    int_en,
  output logic                          timer_run,
  output logic                          timer_flag,
  output logic                          user_flag_zero,
  output logic                          user_flag_one
);
  logic       state_en;
  logic [2:0] state_idx;
  logic       hold;
  logic       req_meta_ff;
  logic       req_sync_ff;
  logic       halt_ff;
  logic       second_ff;
  logic [4:0] tick_cnt_ff;
  logic       clk_out_en_ff;
  logic       clk_phase_ff;
  logic       ale_ff;
  logic       program_store_strobe_ff;
  logic       t1_ff;
  logic       tick_ff;
  logic [tick_pkg::PC_W-1:0] pc_ff;
  logic       cyc_end;
  logic       fetch_point;
  logic       resume;

  state_divider #(
    .OSC_DIV   (tick_pkg::OSC_PER_STATE),
    .STATE_DIV (tick_pkg::STATES_PER_CYC)
  ) u_div (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .hold      (hold),
    .state_en  (state_en),
    .state_idx (state_idx)
  );

  assign cyc_end     = state_en && (state_idx == 3'(tick_pkg::STATES_PER_CYC - 1));
  // the first cycle of a two-cycle op never ends in a fetch
  assign fetch_point = cyc_end && (second_ff || !two_cycle_instr);
  assign resume      = halt_ff && state_en && req_sync_ff;
  assign hold        = halt_ff;

  // request only looked at on state boundaries, second stage alone is used
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      req_meta_ff <= 1'b1;
      req_sync_ff <= 1'b1;
    end else if (state_en) begin
      req_meta_ff <= lnk.step_req_n;
      req_sync_ff <= req_meta_ff;
    end
  end

  // set while the second cycle of a two-cycle op runs
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      second_ff <= 1'b0;
    end else if (cyc_end && !halt_ff) begin
      second_ff <= !second_ff && two_cycle_instr;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      halt_ff <= 1'b0;
    end else if (fetch_point && !halt_ff && !req_sync_ff) begin
      halt_ff <= 1'b1;
    end else if (resume) begin
      halt_ff <= 1'b0;
    end
  end

  // strobe high in the last state of each cycle, pinned high while halted;
  // no reset, so it keeps running while reset is held
  always_ff @(posedge mclk) begin
    ale_ff <= halt_ff || (state_idx == 3'(tick_pkg::ALE_HIGH_STATE));
  end

  // no reset either: with external program select high it pulses through reset
  always_ff @(posedge mclk) begin
    program_store_strobe_ff <= !(external_program_select && !halt_ff
                 && state_idx == 3'(tick_pkg::FETCH_STATE));
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      clk_out_en_ff <= 1'b0;
    end else if (clock_out_enable_instr) begin
      clk_out_en_ff <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      clk_phase_ff <= 1'b0;
    end else if (state_en) begin
      clk_phase_ff <= 1'b1;
    end else begin
      clk_phase_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_ff <= 5'h00;
      tick_ff     <= 1'b0;
    end else begin
      tick_ff <= 1'b0;
      if (timer_start) begin
        tick_cnt_ff <= 5'h00;
      end else if (cyc_end && !halt_ff) begin
        tick_cnt_ff <= (tick_cnt_ff == 5'(TICK_DIV - 1)) ? 5'h00 : tick_cnt_ff + 5'h01;
        tick_ff     <= timer_run && (tick_cnt_ff == 5'(TICK_DIV - 1));
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      t1_ff <= 1'b0;
    end else if (state_en && state_idx == 3'(tick_pkg::FOURTH_STATE)) begin
      t1_ff <= test1_pin;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pc_ff <= tick_pkg::PC_RESET;
    end else if ((fetch_point && !halt_ff && req_sync_ff) || resume) begin
      // a fetch happens at every fetch point that does not halt, and on resume
      pc_ff <= pc_ff + 12'h001;
    end
  end

  // reset state of the core, held here; only timer_run, timer_flag and user_flag_zero are updated after reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sp             <= tick_pkg::SP_RESET;
      reg_bank       <= 1'b0;
      mem_bank       <= 1'b0;
      port_out_en    <= 2'h0;
      int_en         <= 2'h0;
      timer_run      <= 1'b0;
      timer_flag     <= 1'b0;
      user_flag_zero <= 1'b0;
      user_flag_one  <= 1'b0;
    end else begin
      if (timer_start) begin
        timer_run <= 1'b1;
      end
      if (tick_ff) begin
        timer_flag <= 1'b1;
      end
      if (flag_set) begin
        user_flag_zero <= 1'b1;
      end
    end
  end

  // halted address goes out; earlier bus data is dropped, not restored
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lnk.bus_out   <= 8'h00;
      lnk.port2_low <= 4'h0;
    end else begin
      lnk.bus_out   <= pc_ff[7:0];
      lnk.port2_low <= pc_ff[11:8];
    end
  end

  // bus drive follows external program select even while reset is held
  always_ff @(posedge mclk) begin
    lnk.bus_oe <= halt_ff || external_program_select;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lnk.test0_pin <= 1'b0;
      lnk.test0_oe  <= 1'b0;
    end else begin
      lnk.test0_pin <= clk_out_en_ff && clk_phase_ff;
      lnk.test0_oe  <= clk_out_en_ff;
    end
  end

  assign lnk.addr_strobe          = ale_ff;
  assign lnk.program_store_strobe = program_store_strobe_ff;
  assign timer_tick               = tick_ff;
  assign test1_sample             = t1_ff;
  assign halted                   = halt_ff;
  assign pc                       = pc_ff;
endmodule : core_timing

// [logic/tick_pkg.sv]
// Purpose: shared constants for the timing, reset and single-step blocks
// Assumes: one clock mclk at 100 MHz standing in for the oscillator
// Notes:   counts are in oscillator cycles unless named otherwise
package tick_pkg;
  localparam int OSC_PER_STATE   = 3;
  localparam int STATES_PER_CYC  = 5;
  localparam int CYC_PER_TICK    = 32;
  localparam int RESET_MIN_CYC   = 5;
  localparam int FOURTH_STATE    = 3;
  localparam int FETCH_STATE     = 0;
  localparam int ALE_HIGH_STATE  = 4;
  localparam int PC_W            = 12;
  localparam int SP_W            = 3;
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [2:0]  SP_RESET = 3'h0;
  localparam int TWO_CYC_PERIOD  = 4;
endpackage : tick_pkg

// [logic/step_if.sv]
// Purpose: link between the core timing end and the stepping flip-flop end
// Assumes: single clock, all signals synchronous to mclk
// Notes:   no tristate here; only test0 and the bus carry enables, the other outputs have none
interface step_if;
  logic        addr_strobe;
  logic        step_req_n;
  logic        test0_pin;
  logic        test0_oe;
  logic [7:0]  bus_out;
  logic        bus_oe;
  logic [3:0]  port2_low;
  logic        program_store_strobe;
  modport core (output addr_strobe, output test0_pin, output test0_oe, output bus_out,
                output bus_oe, output port2_low, output program_store_strobe,
                input step_req_n);
  modport stepper (input addr_strobe, input bus_out, input port2_low,
                   output step_req_n);
endinterface : step_if

// [logic/state_divider.sv]
// Purpose: oscillator to state clock to machine-cycle timing
// Assumes: mclk is the oscillator
// Notes:   emits one-cycle enables, never derived clocks
module state_divider #(
  parameter int OSC_DIV   = tick_pkg::OSC_PER_STATE,
  parameter int STATE_DIV = tick_pkg::STATES_PER_CYC
) (
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       hold,
  output logic            state_en,
  output logic [2:0]      state_idx
);
  // no reset: the state and cycle strobes must keep running while reset is held;
  // the >= compares pull any stray power-up count back into range
  bit [1:0] osc_cnt_ff;
  bit [2:0] state_ff;

  always_ff @(posedge mclk) begin
    if (osc_cnt_ff >= 2'(OSC_DIV - 1)) begin
      osc_cnt_ff <= 2'h0;
    end else begin
      osc_cnt_ff <= osc_cnt_ff + 2'h1;
    end
  end

  assign state_en = (osc_cnt_ff == 2'(OSC_DIV - 1));

  // hold freezes the state counter but the state clock keeps running; reset overrides hold
  always_ff @(posedge mclk) begin
    if (state_en && !(hold && arst_n)) begin
      state_ff <= (state_ff >= 3'(STATE_DIV - 1)) ? 3'h0 : state_ff + 3'h1;
    end
  end

  assign state_idx = state_ff;
endmodule : state_divider

// [logic/step_ctrl.sv]
// Purpose: external stepping flip-flop end
// Assumes: step_pulse is a one-cycle request to advance one instruction
// Notes:   preset beats clear, as in the discrete flip-flop it mirrors
module step_ctrl (
  input  wire logic  mclk,
  input  wire logic  arst_n,
  input  wire logic  run_mode,
  input  wire logic  step_pulse,
  step_if.stepper    lnk,
  output logic       stopped,
  output logic [11:0] stop_addr
);
  logic req_ff;
  logic stopped_ff;
  logic [2:0] hi_cnt_ff;
  logic [11:0] addr_ff;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      req_ff <= 1'b1;
    end else if (run_mode) begin
      req_ff <= 1'b1;
    end else if (!lnk.addr_strobe) begin
      req_ff <= 1'b0;
    end else if (step_pulse) begin
      req_ff <= 1'b1;
    end
  end

  // a running strobe is one state wide; only a halt keeps it up longer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hi_cnt_ff <= 3'h0;
    end else if (!lnk.addr_strobe) begin
      hi_cnt_ff <= 3'h0;
    end else if (hi_cnt_ff != 3'(tick_pkg::OSC_PER_STATE + 1)) begin
      hi_cnt_ff <= hi_cnt_ff + 3'h1;
    end
  end

  // address valid once the strobe stands high
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stopped_ff <= 1'b0;
      addr_ff    <= 12'h000;
    end else begin
      stopped_ff <= !req_ff && (hi_cnt_ff == 3'(tick_pkg::OSC_PER_STATE + 1));
      addr_ff    <= {lnk.port2_low, lnk.bus_out};
    end
  end

  assign lnk.step_req_n = req_ff;
  assign stopped        = stopped_ff;
  assign stop_addr      = addr_ff;
endmodule : step_ctrl

// [verif/step_link_assertions.sv]
// Purpose: concurrent checks on the link between core timing and stepper
// Assumes: one mclk domain, arst_n active low
// Notes:   a strobe high four mclk in a row can only mean the core is halted
module step_link_assertions (
  input wire logic       mclk,
  input wire logic       arst_n,
  input wire logic       addr_strobe,
  input wire logic       step_req_n,
  input wire logic       test0_pin,
  input wire logic       test0_oe,
  input wire logic [7:0] bus_out,
  input wire logic       bus_oe,
  input wire logic [3:0] port2_low,
  input wire logic       program_store_strobe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  sequence halted_s;
    addr_strobe [*4];
  endsequence
  // request high long enough to pass the two-stage sync
  sequence run_rise_s;
    step_req_n [*8] ##0 $rose(addr_strobe);
  endsequence
  strobe_width_a: assert property ($rose(addr_strobe) |-> addr_strobe [*3])
    else $error("strobe high shorter than one state");
  strobe_gap_a: assert property ($fell(addr_strobe) |-> (!addr_strobe) [*8] ##[3:6] addr_strobe)
    else $error("strobe low span wrong");
  state_clock_a: assert property (test0_oe && $rose(test0_pin) |->
    ##3 ($rose(test0_pin) || !test0_oe))
    else $error("test0 clock period wrong");
  halt_hold_a: assert property (halted_s ##0 !step_req_n |=> addr_strobe)
    else $error("strobe dropped while halted");
  resume_fall_a: assert property (halted_s ##0 $rose(step_req_n) |-> ##[1:12] !addr_strobe)
    else $error("no strobe fall after resume");
  halt_addr_a: assert property (halted_s |-> bus_oe && $stable(bus_out) && $stable(port2_low))
    else $error("halted address not held");
  run_on_a: assert property (run_rise_s |-> ##3 !addr_strobe)
    else $error("core halted with request high");
  program_store_strobe_pulse_a: assert property ($fell(program_store_strobe) |-> ##[1:4] program_store_strobe)
    else $error("program store strobe stuck low");
endmodule : step_link_assertions

// [verif/timing_reset_single_step_tb.sv]
// Purpose: bench for core timing and stepper joined by step_if
// Assumes: TICK_DIV cut to 4 so a timer tick comes every 60 mclk
// Notes:   timing expectations come from tick_pkg counts; address checks compare against the pc output
module timing_reset_single_step_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TDIV = 4;
  localparam int CYC  = tick_pkg::OSC_PER_STATE * tick_pkg::STATES_PER_CYC;
  logic        mclk, arst_n, eps, clk_en, two_cyc, t1, tstart, fset, run_mode, step_pulse;
  logic        tick, t1_smp, halted, rbank, mbank, trun, tflag, uf0, uf1, stopped;
  logic [11:0] pc, stop_addr, a;
  logic [2:0]  sp;
  logic [1:0]  pen, ien;
  int          n_fail, compares, hi, per, one;
  step_if lnk ();
  core_timing #(.TICK_DIV(TDIV)) core_timing_inst (
    .mclk(mclk), .arst_n(arst_n), .external_program_select(eps),
    .clock_out_enable_instr(clk_en), .two_cycle_instr(two_cyc), .test1_pin(t1),
    .timer_start(tstart), .flag_set(fset), .lnk(lnk), .timer_tick(tick),
    .test1_sample(t1_smp), .halted(halted), .pc(pc), .sp(sp), .reg_bank(rbank),
    .mem_bank(mbank), .port_out_en(pen), .int_en(ien), .timer_run(trun),
    .timer_flag(tflag), .user_flag_zero(uf0), .user_flag_one(uf1));
  step_ctrl step_ctrl_inst (.mclk(mclk), .arst_n(arst_n), .run_mode(run_mode),
    .step_pulse(step_pulse), .lnk(lnk), .stopped(stopped), .stop_addr(stop_addr));
  step_link_assertions step_link_assertions_inst (.mclk(mclk), .arst_n(arst_n),
    .addr_strobe(lnk.addr_strobe), .step_req_n(lnk.step_req_n), .test0_pin(lnk.test0_pin),
    .test0_oe(lnk.test0_oe), .bus_out(lnk.bus_out), .bus_oe(lnk.bus_oe),
    .port2_low(lnk.port2_low), .program_store_strobe(lnk.program_store_strobe));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (n_fail == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  function automatic logic pick(input int sel);
    case (sel)
      0: return lnk.addr_strobe;
      1: return lnk.test0_pin;
      2: return tick;
      default: return lnk.program_store_strobe;
    endcase
  endfunction : pick
  task automatic edge_wait(input int sel, input logic v);
    int i;
    i = 0;
    while (pick(sel) !== v && i < 100) begin
      @(posedge mclk);
      i++;
    end
  endtask : edge_wait
  // high time and full period of the chosen signal, in mclk
  task automatic measure(input int sel);
    edge_wait(sel, 1'h0);
    edge_wait(sel, 1'h1);
    hi = 0;
    while (pick(sel) === 1'h1 && hi < 100) begin
      @(posedge mclk);
      hi++;
    end
    per = hi;
    while (pick(sel) === 1'h0 && per < 100) begin
      @(posedge mclk);
      per++;
    end
  endtask : measure
  task automatic wait_stop(input logic v);
    int i;
    i = 0;
    while (stopped !== v && i < 200) begin
      @(posedge mclk);
      i++;
    end
    per = i;
  endtask : wait_stop
  task automatic step_once();
    step_pulse <= 1'h1;
    @(posedge mclk);
    step_pulse <= 1'h0;
    wait_stop(1'h0);
    wait_stop(1'h1);
    repeat (6) @(posedge mclk);
  endtask : step_once
  task automatic reset_vec();
    chk({pc, sp, rbank, mbank}, '0);
    chk({pen, ien, trun, tflag, uf0, uf1}, '0);
    chk({lnk.test0_oe, halted}, '0);
  endtask : reset_vec
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  // whole sequence needs under 2000 mclk
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    {arst_n, eps, clk_en, two_cyc, t1, tstart, fset, step_pulse} = '0;
    run_mode = 1'h1;
    n_fail = 0;
    compares = 0;
    // the ten millisecond power-up hold is scaled down to keep the run short
    repeat (12) @(posedge mclk);
    reset_vec();
    chk(lnk.bus_oe, 1'h0);
    arst_n <= 1'h1;
    measure(0);
    chk(hi, 3);
    chk(per, CYC);
    tstart <= 1'h1;
    @(posedge mclk);
    tstart <= 1'h0;
    measure(2);
    chk({trun, hi[3:0]}, 5'h11);
    chk(per, TDIV * CYC);
    clk_en <= 1'h1;
    fset <= 1'h1;
    t1 <= 1'h1;
    @(posedge mclk);
    {clk_en, fset} <= 2'h0;
    repeat (2 * CYC) @(posedge mclk);
    chk({lnk.test0_oe, uf0, t1_smp}, 3'h7);
    measure(1);
    chk(per, 3);
    t1 <= 1'h0;
    repeat (2 * CYC) @(posedge mclk);
    chk(t1_smp, 1'h0);
    run_mode <= 1'h0;
    wait_stop(1'h1);
    repeat (6) @(posedge mclk);
    chk(lnk.addr_strobe, 1'h1);
    chk({lnk.port2_low, lnk.bus_out}, pc);
    chk(stop_addr, pc);
    a = pc;
    step_once();
    one = per;
    chk(pc, a + 12'h001);
    chk({lnk.port2_low, lnk.bus_out}, pc);
    two_cyc <= 1'h1;
    step_once();
    chk({halted, lnk.addr_strobe}, 2'h3);
    chk(per - one, CYC);
    chk(pc, a + 12'h002);
    two_cyc <= 1'h0;
    run_mode <= 1'h1;
    measure(0);
    chk(per, CYC);
    eps <= 1'h1;
    arst_n <= 1'h0;
    measure(0);
    chk(per, CYC);
    measure(3);
    chk(per, CYC);
    chk(hi, CYC - tick_pkg::OSC_PER_STATE);
    chk(lnk.bus_oe, 1'h1);
    repeat (75) @(posedge mclk);
    reset_vec();
    arst_n <= 1'h1;
    measure(0);
    chk(per, CYC);
    tally_and_finish();
  end
endmodule : timing_reset_single_step_tb
